// File: shared/lsa_regs.svh
// register offsets, field positions and reset values of the limit status alert unit
`ifndef LSA_REGS_SVH
`define LSA_REGS_SVH
`define LSA_ADDR_STATUS_PRI   8'h41
`define LSA_ADDR_STATUS_SEC   8'h42
`define LSA_ADDR_MASK_PRI     8'h74
`define LSA_ADDR_MASK_SEC     8'h75
`define LSA_ADDR_CONFIG       8'h78
`define LSA_PRI_SUMMARY_BIT   7
`define LSA_PRI_REMOTE2_BIT   6
`define LSA_PRI_LOCAL_BIT     5
`define LSA_PRI_REMOTE1_BIT   4
`define LSA_PRI_SUPPLY_BIT    2
`define LSA_PRI_CORE_BIT      1
`define LSA_MASK_PRI_CORE_BIT 0
`define LSA_SEC_DIODE2_BIT    7
`define LSA_SEC_DIODE1_BIT    6
`define LSA_SEC_FAN_FOUR_MASK_BIT      5
`define LSA_SEC_FAN_THREE_FLAG_BIT      4
`define LSA_SEC_FAN_TWO_FLAG_BIT      3
`define LSA_SEC_FAN_ONE_FLAG_BIT      2
`define LSA_SEC_OVT_BIT       1
`define LSA_CFG_ALERT_EN_BIT  0
`define LSA_PRI_STICKY_BITS   8'h76
`define LSA_SEC_STICKY_BITS   8'hfe
`define LSA_MASK_PRI_BITS     8'hf5
`define LSA_MASK_SEC_BITS     8'hfe
`define LSA_MASK_RESET        8'h00
`define LSA_STATUS_RESET      8'h00
`define LSA_READ_ZERO         8'h00
`endif

// File: shared/lsa_pkg.sv
// types of the limit status alert unit
package lsa_pkg;
  typedef struct packed {
    logic [7:0] status_pri;
    logic [7:0] status_sec;
    logic [7:0] mask_pri;
    logic [7:0] mask_sec;
    logic       alert_en;
    logic [7:0] rdata;
    logic       rvalid;
    logic       alert_n;
  } lsa_state_t;
endpackage : lsa_pkg

// File: logic/lsa_unit.sv
// limit status alert unit: sticky status, masks and active-low alert output
`timescale 1ns/100ps
`include "lsa_regs.svh"

// How it works
// - an out-of-limit comparison result sets the channel status bit to one
// - a set status bit stays latched after the condition goes, until read
// - a status read clears only bits whose condition has already gone
// - primary bit 7 reads one whenever any secondary status bit is set
// - primary bits 6, 5, 4 flag remote two, local, remote one temperature
// - primary bit 2 flags the supply channel, bit 1 the core voltage
// - secondary bits 7 and 6 flag second and first diode open or short
// - secondary bit 5 flags fan four slow, or throttle timer limit exceeded
// - secondary bits 4, 3, 2 flag fans three, two, one below minimum speed
// - secondary bit 1 flags a thermal-throttle overtemperature limit exceeded
// - masking never stops a status bit from setting, only the alert
// - alert stays low while out of limit and until the status is read
// - primary mask bit 7 blocks the alert for all secondary conditions
// - primary mask bits 6, 5, 4 mask temperatures, bit 2 supply, bit 0 core
// - secondary mask bits 7, 6 diodes, 4 to 2 fans, 1 overtemperature
// - secondary mask bit 5 masks fan four or throttle timer events
// - status reads over the register port return the latched bits
// - alert is off after reset until config bit 0 is written to one
module lsa_unit (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic [7:0] pri_cond,
  input  wire logic [7:0] sec_cond,
  input  wire logic       fan_four_fail,
  input  wire logic       throttle_timer_exceeded,
  input  wire logic       fan_four_tach_pin_is_throttle,
  output logic            smbalert_n
);

  lsa_pkg::lsa_state_t st_q;
  lsa_pkg::lsa_state_t st_d;

  logic [7:0] pri_src;
  logic [7:0] sec_src;
  logic [7:0] pri_view;
  logic [7:0] pri_unmasked;
  logic [7:0] sec_unmasked;
  logic       rd_pri;
  logic       rd_sec;
  logic       sec_any;

  always_comb begin
    // only the documented primary positions latch
    pri_src = pri_cond & `LSA_PRI_STICKY_BITS;
    // secondary sources; bit 5 chosen by the pin function
    sec_src = sec_cond & `LSA_SEC_STICKY_BITS;
    sec_src[`LSA_SEC_FAN_FOUR_MASK_BIT] = fan_four_tach_pin_is_throttle ? throttle_timer_exceeded
                                                                : fan_four_fail;
    // summary is live, not latched, so it follows the secondary register
    sec_any = |st_q.status_sec;
    pri_view = st_q.status_pri;
    pri_view[`LSA_PRI_SUMMARY_BIT] = sec_any;
    rd_pri = reg_rd && (reg_addr == `LSA_ADDR_STATUS_PRI);
    rd_sec = reg_rd && (reg_addr == `LSA_ADDR_STATUS_SEC);
    // core status sits at bit 1 but its mask at bit 0
    pri_unmasked = st_q.status_pri & ~st_q.mask_pri & `LSA_PRI_STICKY_BITS;
    pri_unmasked[`LSA_PRI_CORE_BIT] = st_q.status_pri[`LSA_PRI_CORE_BIT]
                                      & ~st_q.mask_pri[`LSA_MASK_PRI_CORE_BIT];
    sec_unmasked = st_q.status_sec & ~st_q.mask_sec;
  end

  always_comb begin
    st_d = st_q;
    // clear on read only where the condition has gone; set wins
    if (rd_pri) begin
      st_d.status_pri = st_q.status_pri & pri_src;
    end
    if (rd_sec) begin
      st_d.status_sec = st_q.status_sec & sec_src;
    end
    // sources are never masked on the way into status
    st_d.status_pri = st_d.status_pri | pri_src;
    st_d.status_sec = st_d.status_sec | sec_src;
    if (reg_wr) begin
      case (reg_addr)
        `LSA_ADDR_MASK_PRI: st_d.mask_pri = reg_wdata & `LSA_MASK_PRI_BITS;
        `LSA_ADDR_MASK_SEC: st_d.mask_sec = reg_wdata & `LSA_MASK_SEC_BITS;
        `LSA_ADDR_CONFIG:   st_d.alert_en = reg_wdata[`LSA_CFG_ALERT_EN_BIT];
        default:            st_d.alert_en = st_q.alert_en;
      endcase
    end
    // reads return the latched value before any clear
    st_d.rvalid = reg_rd;
    st_d.rdata  = `LSA_READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `LSA_ADDR_STATUS_PRI: st_d.rdata = pri_view;
        `LSA_ADDR_STATUS_SEC: st_d.rdata = st_q.status_sec;
        `LSA_ADDR_MASK_PRI:   st_d.rdata = st_q.mask_pri;
        `LSA_ADDR_MASK_SEC:   st_d.rdata = st_q.mask_sec;
        `LSA_ADDR_CONFIG:     st_d.rdata = {7'h00, st_q.alert_en};
        default:              st_d.rdata = `LSA_READ_ZERO;
      endcase
    end
    // alert from sticky bits, one cycle behind the status
    st_d.alert_n = ~(st_q.alert_en
                     && ((|pri_unmasked)
                         || ((|sec_unmasked) && !st_q.mask_pri[`LSA_PRI_SUMMARY_BIT])));
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q.status_pri <= `LSA_STATUS_RESET;
      st_q.status_sec <= `LSA_STATUS_RESET;
      st_q.mask_pri   <= `LSA_MASK_RESET;
      st_q.mask_sec   <= `LSA_MASK_RESET;
      st_q.alert_en   <= 1'b0;
      st_q.rdata      <= `LSA_READ_ZERO;
      st_q.rvalid     <= 1'b0;
      st_q.alert_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign smbalert_n = st_q.alert_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_set_on_cond;
    pri_cond[`LSA_PRI_LOCAL_BIT] |=> st_q.status_pri[`LSA_PRI_LOCAL_BIT];
  endproperty
  a_set_on_cond: assert property (p_set_on_cond) else $error("status not set");

  property p_sticky;
    st_q.status_sec[`LSA_SEC_FAN_ONE_FLAG_BIT] && !rd_sec |=> st_q.status_sec[`LSA_SEC_FAN_ONE_FLAG_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_clear_on_read;
    rd_pri && !pri_cond[`LSA_PRI_SUPPLY_BIT] |=> !st_q.status_pri[`LSA_PRI_SUPPLY_BIT];
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear");

  property p_summary;
    rd_pri |=> reg_rvalid && (reg_rdata[7] == $past(sec_any));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_fan_four_mask_mux;
    fan_four_tach_pin_is_throttle && throttle_timer_exceeded
      |=> st_q.status_sec[`LSA_SEC_FAN_FOUR_MASK_BIT];
  endproperty
  a_fan_four_mask_mux: assert property (p_fan_four_mask_mux) else $error("fan four flag missing");

  property p_masked_sets;
    st_q.mask_sec[`LSA_SEC_OVT_BIT] && sec_cond[`LSA_SEC_OVT_BIT]
      |=> st_q.status_sec[`LSA_SEC_OVT_BIT];
  endproperty
  a_masked_sets: assert property (p_masked_sets) else $error("masked source not set");

  property p_alert_low;
    st_q.alert_en && st_q.status_pri[`LSA_PRI_REMOTE1_BIT]
      && !st_q.mask_pri[`LSA_PRI_REMOTE1_BIT] |=> !smbalert_n;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not asserted");

  property p_summary_mask;
    st_q.mask_pri[`LSA_PRI_SUMMARY_BIT] && !(|pri_unmasked) |=> smbalert_n;
  endproperty
  a_summary_mask: assert property (p_summary_mask) else $error("summary mask leaked");

  property p_alert_disabled;
    !st_q.alert_en |=> smbalert_n;
  endproperty
  a_alert_disabled: assert property (p_alert_disabled) else $error("alert while off");

  property p_rvalid_pulse;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  property p_rvalid_idle;
    !reg_rd |=> !reg_rvalid && (reg_rdata == 8'h00);
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("read data not idle");

  property p_read_sec_data;
    rd_sec |=> reg_rdata == $past(st_q.status_sec);
  endproperty
  a_read_sec_data: assert property (p_read_sec_data) else $error("secondary read wrong");

  property p_read_pri_data;
    rd_pri |=> reg_rdata[6:0] == $past(st_q.status_pri[6:0]);
  endproperty
  a_read_pri_data: assert property (p_read_pri_data) else $error("primary read wrong");

  property p_set_remote2;
    pri_cond[`LSA_PRI_REMOTE2_BIT] |=> st_q.status_pri[`LSA_PRI_REMOTE2_BIT];
  endproperty
  a_set_remote2: assert property (p_set_remote2) else $error("remote two not set");

  property p_set_remote1;
    pri_cond[`LSA_PRI_REMOTE1_BIT] |=> st_q.status_pri[`LSA_PRI_REMOTE1_BIT];
  endproperty
  a_set_remote1: assert property (p_set_remote1) else $error("remote one not set");

  property p_set_supply;
    pri_cond[`LSA_PRI_SUPPLY_BIT] |=> st_q.status_pri[`LSA_PRI_SUPPLY_BIT];
  endproperty
  a_set_supply: assert property (p_set_supply) else $error("supply not set");

  property p_set_core;
    pri_cond[`LSA_PRI_CORE_BIT] |=> st_q.status_pri[`LSA_PRI_CORE_BIT];
  endproperty
  a_set_core: assert property (p_set_core) else $error("core not set");

  property p_set_diode2;
    sec_cond[`LSA_SEC_DIODE2_BIT] |=> st_q.status_sec[`LSA_SEC_DIODE2_BIT];
  endproperty
  a_set_diode2: assert property (p_set_diode2) else $error("second diode not set");

  property p_set_diode1;
    sec_cond[`LSA_SEC_DIODE1_BIT] |=> st_q.status_sec[`LSA_SEC_DIODE1_BIT];
  endproperty
  a_set_diode1: assert property (p_set_diode1) else $error("first diode not set");

  property p_set_fan_three_flag;
    sec_cond[`LSA_SEC_FAN_THREE_FLAG_BIT] |=> st_q.status_sec[`LSA_SEC_FAN_THREE_FLAG_BIT];
  endproperty
  a_set_fan_three_flag: assert property (p_set_fan_three_flag) else $error("fan three not set");

  property p_set_fan_two_flag;
    sec_cond[`LSA_SEC_FAN_TWO_FLAG_BIT] |=> st_q.status_sec[`LSA_SEC_FAN_TWO_FLAG_BIT];
  endproperty
  a_set_fan_two_flag: assert property (p_set_fan_two_flag) else $error("fan two not set");

  property p_set_ovt;
    sec_cond[`LSA_SEC_OVT_BIT] |=> st_q.status_sec[`LSA_SEC_OVT_BIT];
  endproperty
  a_set_ovt: assert property (p_set_ovt) else $error("overtemperature not set");

  property p_fan_four_mask_tach;
    !fan_four_tach_pin_is_throttle && fan_four_fail |=> st_q.status_sec[`LSA_SEC_FAN_FOUR_MASK_BIT];
  endproperty
  a_fan_four_mask_tach: assert property (p_fan_four_mask_tach) else $error("fan four tach not set");

  property p_sticky_pri;
    st_q.status_pri[`LSA_PRI_LOCAL_BIT] && !rd_pri |=> st_q.status_pri[`LSA_PRI_LOCAL_BIT];
  endproperty
  a_sticky_pri: assert property (p_sticky_pri) else $error("primary bit lost");

  property p_held_on_read;
    rd_sec && sec_cond[`LSA_SEC_DIODE2_BIT] |=> st_q.status_sec[`LSA_SEC_DIODE2_BIT];
  endproperty
  a_held_on_read: assert property (p_held_on_read) else $error("live bit cleared");

  property p_clear_sec;
    rd_sec && !sec_cond[`LSA_SEC_FAN_TWO_FLAG_BIT] |=> !st_q.status_sec[`LSA_SEC_FAN_TWO_FLAG_BIT];
  endproperty
  a_clear_sec: assert property (p_clear_sec) else $error("secondary not cleared");

  property p_alert_sec;
    st_q.alert_en && st_q.status_sec[`LSA_SEC_FAN_ONE_FLAG_BIT] && !st_q.mask_sec[`LSA_SEC_FAN_ONE_FLAG_BIT]
      && !st_q.mask_pri[`LSA_PRI_SUMMARY_BIT] |=> !smbalert_n;
  endproperty
  a_alert_sec: assert property (p_alert_sec) else $error("secondary alert missing");

  property p_core_alert;
    st_q.alert_en && st_q.status_pri[`LSA_PRI_CORE_BIT]
      && !st_q.mask_pri[`LSA_MASK_PRI_CORE_BIT] |=> !smbalert_n;
  endproperty
  a_core_alert: assert property (p_core_alert) else $error("core alert missing");

  property p_quiet;
    (st_q.status_pri == 8'h00) && (st_q.status_sec == 8'h00) |=> smbalert_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alert with no status");

  property p_sec_masked_quiet;
    (st_q.status_pri == 8'h00) && ((st_q.status_sec & ~st_q.mask_sec) == 8'h00) |=> smbalert_n;
  endproperty
  a_sec_masked_quiet: assert property (p_sec_masked_quiet) else $error("mask leaked");

  property p_fan_four_mask_masked;
    (st_q.status_pri == 8'h00) && st_q.mask_sec[`LSA_SEC_FAN_FOUR_MASK_BIT]
      && ((st_q.status_sec & 8'hdf) == 8'h00) |=> smbalert_n;
  endproperty
  a_fan_four_mask_masked: assert property (p_fan_four_mask_masked) else $error("fan four mask leaked");

  property p_mask_write;
    reg_wr && (reg_addr == `LSA_ADDR_MASK_PRI)
      |=> st_q.mask_pri == ($past(reg_wdata) & `LSA_MASK_PRI_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_mask_sec_read;
    reg_rd && (reg_addr == `LSA_ADDR_MASK_SEC) |=> reg_rdata == $past(st_q.mask_sec);
  endproperty
  a_mask_sec_read: assert property (p_mask_sec_read) else $error("mask read wrong");

  property p_enable_write;
    reg_wr && (reg_addr == `LSA_ADDR_CONFIG) |=> st_q.alert_en == $past(reg_wdata[0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  c_alert: cover property (st_q.alert_en ##1 !smbalert_n ##[1:20] smbalert_n);
  c_read_clear: cover property (st_q.status_sec != 8'h00 ##0 rd_sec ##1 st_q.status_sec == 8'h00);
  c_read_held: cover property (rd_pri && (pri_src != 8'h00) ##1 st_q.status_pri != 8'h00);

endmodule : lsa_unit

// File: verif/lsa_host.sv
// host model driving the register strobe port of the unit
`timescale 1ns/100ps
module lsa_host (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // one strobe per access, held until the taking edge
  task acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released bus shows no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : lsa_host

// File: verif/tb_lsa_unit.sv
// self-checking bench of the limit status alert unit
`timescale 1ns/100ps
module tb_lsa_unit;
  logic       mclk, resetn, reg_rd, reg_wr, reg_rvalid, fan_four_mask, tmr, sel, smbalert_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pri_cond, sec_cond;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cyc = 0;
  lsa_unit u_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pri_cond(pri_cond), .sec_cond(sec_cond), .fan_four_fail(fan_four_mask),
    .throttle_timer_exceeded(tmr), .fan_four_tach_pin_is_throttle(sel),
    .smbalert_n(smbalert_n));
  lsa_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // the run needs about 110 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [7:0] exp);
    u_host.acc(a, 1'b0, 8'h00);
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(a, 1'b1, d);
  endtask : wr
  task tick();
    @(posedge mclk);
    #1;
  endtask : tick
  // condition high for one edge, returns once the alert has had its cycle
  task pulse(input logic [7:0] p, input logic [7:0] s, input logic f, input logic t);
    tick();
    {pri_cond, sec_cond, fan_four_mask, tmr} = {p, s, f, t};
    tick();
    {pri_cond, sec_cond, fan_four_mask, tmr} = 18'h0;
    tick();
  endtask : pulse
  task alert(input logic exp);
    chk({7'h00, smbalert_n}, {7'h00, exp});
  endtask : alert
  task t_reset();
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h50, 8'h00);
    alert(1'b1);
    $display("test reset done");
  endtask : t_reset
  task t_sticky();
    pulse(8'h76, 8'h00, 1'b0, 1'b0);
    alert(1'b1);
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h76);
    rd(8'h41, 8'h00);
    $display("test sticky done");
  endtask : t_sticky
  task t_held();
    {sec_cond, fan_four_mask} = {8'hde, 1'b1};
    rd(8'h41, 8'h80);
    rd(8'h42, 8'hfe);
    {sec_cond, fan_four_mask} = 9'h0;
    rd(8'h42, 8'hfe);
    rd(8'h42, 8'h00);
    rd(8'h41, 8'h00);
    $display("test held done");
  endtask : t_held
  task t_alert();
    wr(8'h78, 8'h01);
    rd(8'h78, 8'h01);
    pulse(8'h20, 8'h00, 1'b0, 1'b0);
    alert(1'b0);
    repeat (4) tick();
    alert(1'b0);
    wr(8'h74, 8'hff);
    rd(8'h74, 8'hf5);
    alert(1'b1);
    pulse(8'h20, 8'h00, 1'b0, 1'b0);
    rd(8'h41, 8'h20);
    wr(8'h74, 8'h01);
    pulse(8'h02, 8'h00, 1'b0, 1'b0);
    alert(1'b1);
    wr(8'h74, 8'h00);
    tick();
    alert(1'b0);
    rd(8'h41, 8'h02);
    tick();
    alert(1'b1);
    $display("test alert done");
  endtask : t_alert
  task t_sec();
    pulse(8'h00, 8'h04, 1'b0, 1'b0);
    alert(1'b0);
    wr(8'h74, 8'h80);
    tick();
    alert(1'b1);
    wr(8'h74, 8'h00);
    wr(8'h75, 8'hff);
    rd(8'h75, 8'hfe);
    alert(1'b1);
    wr(8'h75, 8'h00);
    tick();
    alert(1'b0);
    rd(8'h42, 8'h04);
    tick();
    alert(1'b1);
    $display("test sec done");
  endtask : t_sec
  task t_fan_four_mask();
    sel = 1'b1;
    pulse(8'h00, 8'h20, 1'b1, 1'b0);
    rd(8'h42, 8'h00);
    pulse(8'h00, 8'h00, 1'b0, 1'b1);
    rd(8'h42, 8'h20);
    sel = 1'b0;
    wr(8'h75, 8'h20);
    pulse(8'h00, 8'h00, 1'b1, 1'b0);
    alert(1'b1);
    rd(8'h42, 8'h20);
    $display("test fan_four_mask done");
  endtask : t_fan_four_mask
  task print_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    {resetn, pri_cond, sec_cond, fan_four_mask, tmr, sel} = 20'h0;
    repeat (20) tick();
    resetn = 1'b1;
    t_reset();
    t_sticky();
    t_held();
    t_alert();
    t_sec();
    t_fan_four_mask();
    print_verdict();
  end
endmodule : tb_lsa_unit
